// File: shared/ecgfr_pkg.sv
// Constants, register map and decode functions for the fast recovery
// and calibration control block.
// Assumes one output sample strobe per sample and a 32.768 kHz master clock pin.
package ecgfr_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 24;
	localparam int SAMP_W = 18;
	localparam int CMD_BITS = 8;
	localparam int FRAME_BITS = 32;
	localparam int BIT_CNT_W = 6;

	localparam logic [ADDR_W-1:0] ADDR_DYN = 7'h05;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 7'h06;
	localparam logic [ADDR_W-1:0] ADDR_CAL = 7'h12;
	localparam logic [ADDR_W-1:0] ADDR_EMUX = 7'h14;
	localparam logic [ADDR_W-1:0] ADDR_ECG = 7'h15;
	localparam logic [DATA_W-1:0] REG_RESET = 24'h000000;

	localparam int DYN_MODE_LSB = 22;
	localparam int DYN_THR_LSB = 16;
	localparam int CAL_EN_BIT = 22;
	localparam int CAL_BIP_BIT = 21;
	localparam int CAL_MAG_BIT = 20;
	localparam int CAL_FREQ_LSB = 12;
	localparam int CAL_FIFTY_BIT = 11;
	localparam int CAL_WIDTH_LSB = 0;
	localparam int EMUX_ISO_BIT = 23;
	localparam int EMUX_ROUTE_LSB = 16;
	localparam int ECG_RATE_LSB = 22;
	localparam int ECG_GAIN_LSB = 16;
	localparam int STAT_ACTIVE_BIT = 23;
	localparam int STAT_STATE_LSB = 16;

	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_MANUAL = 2'h1;
	localparam logic [1:0] MODE_AUTO = 2'h2;
	localparam logic [1:0] RATE_512 = 2'h0;
	localparam logic [1:0] RATE_256 = 2'h1;
	localparam int THR_SHIFT = 11;

	localparam int SAT_TIME_MS = 125;
	localparam int MS_PER_S = 1000;
	localparam int SPS_512 = 512;
	localparam int SPS_256 = 256;
	localparam int SPS_128 = 128;
	localparam logic [7:0] REC_SAMPLES_512 = 8'hff;
	localparam logic [7:0] REC_SAMPLES_256 = 8'h7f;
	localparam logic [7:0] REC_SAMPLES_128 = 8'h3f;
	localparam logic [7:0] SAT_LIM_512 = 8'(SAT_TIME_MS * SPS_512 / MS_PER_S);
	localparam logic [7:0] SAT_LIM_256 = 8'(SAT_TIME_MS * SPS_256 / MS_PER_S);
	localparam logic [7:0] SAT_LIM_128 = 8'(SAT_TIME_MS * SPS_128 / MS_PER_S);

	localparam int CAL_CNT_W = 22;
	localparam int CAL_WIDTH_W = 11;
	localparam logic [CAL_CNT_W-1:0] CAL_BASE_TICKS = 22'h000080;
	localparam logic [7:0] GAIN_BASE = 8'h14;

	function automatic logic [7:0] satLimit(input logic [1:0] rate);
		case (rate)
			RATE_512: satLimit = SAT_LIM_512;
			RATE_256: satLimit = SAT_LIM_256;
			default: satLimit = SAT_LIM_128;
		endcase
	endfunction : satLimit

	function automatic logic [7:0] recLimit(input logic [1:0] rate);
		case (rate)
			RATE_512: recLimit = REC_SAMPLES_512;
			RATE_256: recLimit = REC_SAMPLES_256;
			default: recLimit = REC_SAMPLES_128;
		endcase
	endfunction : recLimit

	function automatic logic [7:0] overallGain(input logic [1:0] sel);
		overallGain = GAIN_BASE << sel;
	endfunction : overallGain
endpackage : ecgfr_pkg

// File: shared/ecgfr_cfg_if.sv
// Interface carrying configuration and state between the top and its two engines.
// Assumes all three modules share one clock.
`timescale 1ns/1ns
interface ecgfr_cfg_if;
	logic [1:0] recMode;
	logic [5:0] satThr;
	logic [1:0] rateSel;
	logic fastActive;
	logic [1:0] recState;
	logic calEn;
	logic [2:0] calFreq;
	logic calFifty;
	logic [10:0] calWidth;
	logic calHigh;
	modport top (output recMode, satThr, rateSel, calEn, calFreq, calFifty, calWidth,
		input fastActive, recState, calHigh);
	modport rec (input recMode, satThr, rateSel, output fastActive, recState);
	modport cal (input calEn, calFreq, calFifty, calWidth, output calHigh);
endinterface : ecgfr_cfg_if

// File: hdl/ecgfr_recovery.sv
// Overdrive watcher: saturation and below-threshold timers and settling period.
// Assumes sampleStrobe pulses once per output sample with sampleData valid.
`timescale 1ns/1ns
module ecgfr_recovery (
	input wire logic clk,
	input wire logic rstN,
	input wire logic sampleStrobe,
	input wire logic signed [ecgfr_pkg::SAMP_W-1:0] sampleData,
	ecgfr_cfg_if.rec cfg
);
	typedef enum logic [1:0] {ECGFR_IDLE, ECGFR_WATCH, ECGFR_SETTLE} ecgfr_rec_t;
	ecgfr_rec_t state_q, state_d;
	logic [7:0] satCnt_q, satCnt_d, blwCnt_q, blwCnt_d, recCnt_q, recCnt_d;
	logic [ecgfr_pkg::SAMP_W-1:0] mag, thr;
	logic over, isAuto;

	always_comb begin
		mag = sampleData[ecgfr_pkg::SAMP_W-1] ? ecgfr_pkg::SAMP_W'(-sampleData)
			: ecgfr_pkg::SAMP_W'(sampleData);
		thr = ecgfr_pkg::SAMP_W'({cfg.satThr, {ecgfr_pkg::THR_SHIFT{1'b0}}});
		over = mag > thr;
		isAuto = cfg.recMode == ecgfr_pkg::MODE_AUTO;
		state_d = state_q;
		satCnt_d = satCnt_q;
		blwCnt_d = blwCnt_q;
		recCnt_d = recCnt_q;
		if (!isAuto) begin
			// Leaving automatic mode drops any partial count.
			state_d = ECGFR_IDLE;
			satCnt_d = '0;
			blwCnt_d = '0;
			recCnt_d = '0;
		end else if (sampleStrobe) begin
			case (state_q)
				ECGFR_IDLE: begin
					if (over) begin
						state_d = ECGFR_WATCH;
						satCnt_d = 8'h01;
					end
				end
				ECGFR_WATCH: begin
					if (over) begin
						satCnt_d = satCnt_q + 8'h01;
						blwCnt_d = '0;
					end else begin
						blwCnt_d = blwCnt_q + 8'h01;
					end
					if (over && satCnt_q >= ecgfr_pkg::satLimit(cfg.rateSel)) begin
						state_d = ECGFR_SETTLE;
						satCnt_d = '0;
						recCnt_d = '0;
					end else if (!over && blwCnt_q + 8'h01 >= ecgfr_pkg::satLimit(cfg.rateSel)) begin
						state_d = ECGFR_IDLE;
						satCnt_d = '0;
						blwCnt_d = '0;
					end
				end
				ECGFR_SETTLE: begin
					recCnt_d = recCnt_q + 8'h01;
					if (recCnt_d >= ecgfr_pkg::recLimit(cfg.rateSel)) begin
						state_d = ECGFR_IDLE;
						recCnt_d = '0;
						blwCnt_d = '0;
					end
				end
				default: state_d = ECGFR_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			state_q <= ECGFR_IDLE;
			satCnt_q <= '0;
			blwCnt_q <= '0;
			recCnt_q <= '0;
		end else begin
			state_q <= state_d;
			satCnt_q <= satCnt_d;
			blwCnt_q <= blwCnt_d;
			recCnt_q <= recCnt_d;
		end
	end

	assign cfg.fastActive = (state_q == ECGFR_SETTLE) || (cfg.recMode == ecgfr_pkg::MODE_MANUAL);
	assign cfg.recState = state_q;
endmodule : ecgfr_recovery

// File: hdl/ecgfr_cal_gen.sv
// Calibration waveform timing, counted in master clock ticks.
// Assumes fclkIn is the 32.768 kHz master clock, sampled as a plain input.
`timescale 1ns/1ns
module ecgfr_cal_gen (
	input wire logic clk,
	input wire logic rstN,
	input wire logic fclkIn,
	ecgfr_cfg_if.cal cfg
);
	logic fclkPrev_q, fclkPrev_d;
	logic [ecgfr_pkg::CAL_CNT_W-1:0] cnt_q, cnt_d, period, highTicks;
	logic high_q, high_d;

	always_comb begin
		// Each step of the frequency field divides the rate by four.
		period = ecgfr_pkg::CAL_BASE_TICKS << {cfg.calFreq, 1'b0};
		highTicks = cfg.calFifty ? (period >> 1)
			: ecgfr_pkg::CAL_CNT_W'(cfg.calWidth) + 22'h000001;
		fclkPrev_d = fclkIn;
		cnt_d = cnt_q;
		high_d = high_q;
		if (!cfg.calEn) begin
			cnt_d = '0;
			high_d = 1'b0;
		end else if (fclkIn && !fclkPrev_q) begin
			cnt_d = (cnt_q >= period - 22'h000001) ? '0 : cnt_q + 22'h000001;
			high_d = cnt_d < highTicks;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			fclkPrev_q <= 1'b0;
			cnt_q <= '0;
			high_q <= 1'b0;
		end else begin
			fclkPrev_q <= fclkPrev_d;
			cnt_q <= cnt_d;
			high_q <= high_d;
		end
	end

	assign cfg.calHigh = high_q;
endmodule : ecgfr_cal_gen

// File: hdl/ecgfr_top.sv
// Top of the fast recovery and calibration control block with its serial register port.
// Assumes serial pins and samples are synchronous to ref_clk and sclk is slower than ref_clk/4.
`timescale 1ns/1ns
module ecgfr_top (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic csN,
	input wire logic sclk,
	input wire logic sdi,
	output logic sdo_q,
	output logic sdoOe_q,
	input wire logic masterSampleClock,
	input wire logic sampleStrobe,
	input wire logic signed [ecgfr_pkg::SAMP_W-1:0] sampleData,
	output logic [ecgfr_pkg::SAMP_W-1:0] sampleOut_q,
	output logic sampleOutValid_q,
	output logic sampleOutTag_q,
	output logic fastSettle_q,
	output logic isolClosed_q,
	output logic calActive_q,
	output logic calHigh_q,
	output logic calBipolar_q,
	output logic calBigAmp_q,
	output logic [1:0] calRoute_q,
	output logic [1:0] progAmpGain_q,
	output logic [7:0] overallGain_q
);
	logic rstMeta_q, rstN_q;
	logic sclkPrev_q, sclkPrev_d;
	logic [ecgfr_pkg::BIT_CNT_W-1:0] bitCnt_q, bitCnt_d;
	logic [ecgfr_pkg::FRAME_BITS-1:0] shiftIn_q, shiftIn_d;
	logic [ecgfr_pkg::DATA_W-1:0] shiftOut_q, shiftOut_d;
	logic sdo_d, sdoOe_d;
	logic [ecgfr_pkg::DATA_W-1:0] dyn_q, dyn_d, cal_q, cal_d, emux_q, emux_d, ecg_q, ecg_d;
	logic [ecgfr_pkg::DATA_W-1:0] readData, statusWord;
	logic [ecgfr_pkg::SAMP_W-1:0] sampleOut_d;
	logic sampleOutValid_d, sampleOutTag_d, fastSettle_d, isolClosed_d;
	logic calActive_d, calHigh_d, calBipolar_d, calBigAmp_d;
	logic [1:0] calRoute_d, progAmpGain_d;
	logic [7:0] overallGain_d;
	logic sclkRise, sclkFall, isRead;
	logic readFlag_q, readFlag_d;
	logic [ecgfr_pkg::ADDR_W-1:0] addr;
	logic [ecgfr_pkg::FRAME_BITS-1:0] frame;

	ecgfr_cfg_if cfg ();

	// Reset is released through two flops so that every engine leaves reset on one edge.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta_q <= 1'b0;
			rstN_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstN_q <= rstMeta_q;
		end
	end

	ecgfr_recovery u_recovery (
		.clk(ref_clk),
		.rstN(rstN_q),
		.sampleStrobe(sampleStrobe),
		.sampleData(sampleData),
		.cfg(cfg.rec)
	);

	// All calibration timing follows the external master clock.
	ecgfr_cal_gen u_cal_gen (
		.clk(ref_clk),
		.rstN(rstN_q),
		.fclkIn(masterSampleClock),
		.cfg(cfg.cal)
	);

	assign cfg.recMode = dyn_q[ecgfr_pkg::DYN_MODE_LSB +: 2];
	assign cfg.satThr = dyn_q[ecgfr_pkg::DYN_THR_LSB +: 6];
	assign cfg.rateSel = ecg_q[ecgfr_pkg::ECG_RATE_LSB +: 2];
	assign cfg.calEn = cal_q[ecgfr_pkg::CAL_EN_BIT];
	assign cfg.calFreq = cal_q[ecgfr_pkg::CAL_FREQ_LSB +: 3];
	assign cfg.calFifty = cal_q[ecgfr_pkg::CAL_FIFTY_BIT];
	assign cfg.calWidth = cal_q[ecgfr_pkg::CAL_WIDTH_LSB +: ecgfr_pkg::CAL_WIDTH_W];

	// Serial register port: eight command bits then 24 data bits, MSB first.
	always_comb begin
		sclkRise = sclk && !sclkPrev_q && !csN;
		sclkFall = !sclk && sclkPrev_q && !csN;
		frame = {shiftIn_q[ecgfr_pkg::FRAME_BITS-2:0], sdi};
		// At the last rising edge the address sits one place below the top of the shifter.
		addr = shiftIn_q[ecgfr_pkg::FRAME_BITS-2 -: ecgfr_pkg::ADDR_W];
		isRead = readFlag_q;
		statusWord = '0;
		statusWord[ecgfr_pkg::STAT_ACTIVE_BIT] = cfg.fastActive;
		statusWord[ecgfr_pkg::STAT_STATE_LSB +: 2] = cfg.recState;
		case (frame[ecgfr_pkg::CMD_BITS-1 -: ecgfr_pkg::ADDR_W])
			ecgfr_pkg::ADDR_DYN: readData = dyn_q;
			ecgfr_pkg::ADDR_STATUS: readData = statusWord;
			ecgfr_pkg::ADDR_CAL: readData = cal_q;
			ecgfr_pkg::ADDR_EMUX: readData = emux_q;
			ecgfr_pkg::ADDR_ECG: readData = ecg_q;
			default: readData = '0;
		endcase
		sclkPrev_d = sclk;
		bitCnt_d = bitCnt_q;
		readFlag_d = readFlag_q;
		shiftIn_d = shiftIn_q;
		shiftOut_d = shiftOut_q;
		sdo_d = sdo_q;
		sdoOe_d = sdoOe_q;
		dyn_d = dyn_q;
		cal_d = cal_q;
		emux_d = emux_q;
		ecg_d = ecg_q;
		if (csN) begin
			bitCnt_d = '0;
			readFlag_d = 1'b0;
			sdoOe_d = 1'b0;
			sdo_d = 1'b0;
		end else if (sclkRise) begin
			shiftIn_d = frame;
			bitCnt_d = bitCnt_q + 6'h01;
			if (bitCnt_q == 6'(ecgfr_pkg::CMD_BITS - 1)) begin
				// The direction bit is kept apart because the shifter keeps moving it.
				readFlag_d = frame[0];
				if (frame[0]) begin
					shiftOut_d = readData;
				end
			end
			if (bitCnt_q == 6'(ecgfr_pkg::FRAME_BITS - 1) && !isRead) begin
				case (addr)
					ecgfr_pkg::ADDR_DYN: dyn_d = frame[ecgfr_pkg::DATA_W-1:0];
					ecgfr_pkg::ADDR_CAL: cal_d = frame[ecgfr_pkg::DATA_W-1:0];
					ecgfr_pkg::ADDR_EMUX: emux_d = frame[ecgfr_pkg::DATA_W-1:0];
					ecgfr_pkg::ADDR_ECG: ecg_d = frame[ecgfr_pkg::DATA_W-1:0];
					default: dyn_d = dyn_q;
				endcase
			end
		end else if (sclkFall && bitCnt_q >= 6'(ecgfr_pkg::CMD_BITS)
			&& bitCnt_q < 6'(ecgfr_pkg::FRAME_BITS) && isRead) begin
			sdoOe_d = 1'b1;
			sdo_d = shiftOut_q[ecgfr_pkg::DATA_W-1];
			shiftOut_d = {shiftOut_q[ecgfr_pkg::DATA_W-2:0], 1'b0};
		end
	end

	always_ff @(posedge ref_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			sclkPrev_q <= 1'b0;
			bitCnt_q <= '0;
			readFlag_q <= 1'b0;
			shiftIn_q <= '0;
			shiftOut_q <= '0;
			sdo_q <= 1'b0;
			sdoOe_q <= 1'b0;
			dyn_q <= ecgfr_pkg::REG_RESET;
			cal_q <= ecgfr_pkg::REG_RESET;
			emux_q <= ecgfr_pkg::REG_RESET;
			ecg_q <= ecgfr_pkg::REG_RESET;
		end else begin
			sclkPrev_q <= sclkPrev_d;
			bitCnt_q <= bitCnt_d;
			readFlag_q <= readFlag_d;
			shiftIn_q <= shiftIn_d;
			shiftOut_q <= shiftOut_d;
			sdo_q <= sdo_d;
			sdoOe_q <= sdoOe_d;
			dyn_q <= dyn_d;
			cal_q <= cal_d;
			emux_q <= emux_d;
			ecg_q <= ecg_d;
		end
	end

	// Output stage: every pin below is a flop so downstream timing is clean.
	always_comb begin
		sampleOut_d = sampleOut_q;
		sampleOutTag_d = sampleOutTag_q;
		sampleOutValid_d = sampleStrobe;
		if (sampleStrobe) begin
			sampleOut_d = ecgfr_pkg::SAMP_W'(sampleData);
			sampleOutTag_d = cfg.fastActive;
		end
		fastSettle_d = cfg.fastActive;
		// Switches close only on request; opening them before calibrating is the host's job.
		isolClosed_d = emux_q[ecgfr_pkg::EMUX_ISO_BIT];
		calActive_d = cal_q[ecgfr_pkg::CAL_EN_BIT];
		calHigh_d = cfg.calHigh;
		calBipolar_d = cal_q[ecgfr_pkg::CAL_BIP_BIT];
		calBigAmp_d = cal_q[ecgfr_pkg::CAL_MAG_BIT];
		calRoute_d = emux_q[ecgfr_pkg::EMUX_ROUTE_LSB +: 2];
		progAmpGain_d = ecg_q[ecgfr_pkg::ECG_GAIN_LSB +: 2];
		overallGain_d = ecgfr_pkg::overallGain(progAmpGain_d);
	end

	always_ff @(posedge ref_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			sampleOut_q <= '0;
			sampleOutValid_q <= 1'b0;
			sampleOutTag_q <= 1'b0;
			fastSettle_q <= 1'b0;
			isolClosed_q <= 1'b0;
			calActive_q <= 1'b0;
			calHigh_q <= 1'b0;
			calBipolar_q <= 1'b0;
			calBigAmp_q <= 1'b0;
			calRoute_q <= '0;
			progAmpGain_q <= '0;
			overallGain_q <= ecgfr_pkg::GAIN_BASE;
		end else begin
			sampleOut_q <= sampleOut_d;
			sampleOutValid_q <= sampleOutValid_d;
			sampleOutTag_q <= sampleOutTag_d;
			fastSettle_q <= fastSettle_d;
			isolClosed_q <= isolClosed_d;
			calActive_q <= calActive_d;
			calHigh_q <= calHigh_d;
			calBipolar_q <= calBipolar_d;
			calBigAmp_q <= calBigAmp_d;
			calRoute_q <= calRoute_d;
			progAmpGain_q <= progAmpGain_d;
			overallGain_q <= overallGain_d;
		end
	end
endmodule : ecgfr_top

// File: tb/ecgfr_host_model.sv
// Host model: serial register master for the block.
// Assumes clk is ref_clk; sclk high for three clocks and low for four.
`timescale 1ns/1ns
module ecgfr_host_model (
	input wire logic clk,
	input wire logic sdo,
	output logic csN,
	output logic sclk,
	output logic sdi
);
	initial begin
		csN = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
	end
	// Read data is taken on sclk rising, long after the falling edge moved it.
	task automatic xfer(input logic [31:0] f, output logic [23:0] rd);
		for (int i = 31; i >= 0; i--) begin
			@(posedge clk) csN <= 1'b0;
			sdi <= f[i];
			repeat (3) @(posedge clk);
			sclk <= 1'b1;
			if (i < 24) rd[i] = sdo;
			repeat (3) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (3) @(posedge clk);
		csN <= 1'b1;
		sdi <= ~sdi;
		@(posedge clk);
	endtask : xfer
endmodule : ecgfr_host_model

// File: tb/ecgfr_assertions.sv
// Checker on the top ports of the recovery block.
// Assumes one ref_clk domain with arst_n as its reset.
`timescale 1ns/1ns
module ecgfr_chk (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic csN,
	input wire logic sdo_q,
	input wire logic sdoOe_q,
	input wire logic sampleStrobe,
	input wire logic signed [ecgfr_pkg::SAMP_W-1:0] sampleData,
	input wire logic [ecgfr_pkg::SAMP_W-1:0] sampleOut_q,
	input wire logic sampleOutValid_q,
	input wire logic sampleOutTag_q,
	input wire logic fastSettle_q,
	input wire logic isolClosed_q,
	input wire logic calActive_q,
	input wire logic calHigh_q,
	input wire logic [1:0] progAmpGain_q,
	input wire logic [7:0] overallGain_q
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);
	a_reset_outputs: assert property (disable iff (1'b0) !arst_n ##1 !arst_n
		|-> !isolClosed_q && !fastSettle_q && overallGain_q == 8'h14)
		else $error("outputs not at reset values");
	a_sample_copy: assert property (sampleStrobe
		|=> sampleOutValid_q && sampleOut_q == $past(sampleData))
		else $error("sample not copied");
	a_sample_hold: assert property (!sampleStrobe
		|=> !sampleOutValid_q && $stable(sampleOut_q) && $stable(sampleOutTag_q))
		else $error("sample output moved without strobe");
	a_tag_settle: assert property (sampleStrobe |=> sampleOutTag_q == fastSettle_q)
		else $error("sample tag differs from settling state");
	a_settle_cause: assert property ($changed(fastSettle_q)
		|-> $past(sampleStrobe, 2) || !$past(csN, 3))
		else $error("settling changed without sample or write");
	a_gain_map: assert property ($stable(progAmpGain_q)
		|-> overallGain_q == (8'h14 << progAmpGain_q))
		else $error("overall gain mismatch");
	a_sdo_idle: assert property (csN && $past(csN) |-> !sdoOe_q && !sdo_q)
		else $error("serial output driven while deselected");
	a_cal_quiet: assert property (!calActive_q && !$past(calActive_q) |-> !calHigh_q)
		else $error("calibration pulse while disabled");
endmodule : ecgfr_chk
bind ecgfr_top ecgfr_chk u_chk (.ref_clk(ref_clk), .arst_n(arst_n), .csN(csN),
	.sdo_q(sdo_q), .sdoOe_q(sdoOe_q), .sampleStrobe(sampleStrobe),
	.sampleData(sampleData), .sampleOut_q(sampleOut_q), .sampleOutValid_q(sampleOutValid_q),
	.sampleOutTag_q(sampleOutTag_q), .fastSettle_q(fastSettle_q),
	.isolClosed_q(isolClosed_q), .calActive_q(calActive_q), .calHigh_q(calHigh_q),
	.progAmpGain_q(progAmpGain_q), .overallGain_q(overallGain_q));

// File: tb/ecgfr_tb.sv
// Self-checking bench for the recovery and calibration block.
// Assumes the host model drives the serial pins; master clock runs fast to keep runs short.
`timescale 1ns/1ns
module ecgfr_tb;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic msClk = 1'b0;
	logic sampleStrobe = 1'b0;
	logic signed [17:0] sampleData = 18'sh00000;
	logic csN, sclk, sdi, sdo_q, sdoOe_q, sampleOutValid_q, sampleOutTag_q, fastSettle_q;
	logic isolClosed_q, calActive_q, calHigh_q, calBipolar_q, calBigAmp_q;
	logic [17:0] sampleOut_q;
	logic [1:0] calRoute_q, progAmpGain_q;
	logic [7:0] overallGain_q;
	logic [15:0] outv, o;
	logic [23:0] rd, d;
	logic [6:0] a;
	int fails = 0, n_compared = 0, cyc = 0, tags = 0;
	time t;
	logic [46:0] rows [9] = '{{7'h15, 24'h000000, 16'h0014}, {7'h15, 24'h010000, 16'h0128},
		{7'h15, 24'h020000, 16'h0250}, {7'h15, 24'h030000, 16'h03a0},
		{7'h14, 24'h800000, 16'h83a0}, {7'h14, 24'h010000, 16'h07a0},
		{7'h14, 24'h020000, 16'h0ba0}, {7'h12, 24'h700000, 16'h7ba0},
		{7'h12, 24'h400800, 16'h4ba0}};
	int limN [3] = '{64, 32, 16};
	logic [23:0] setN [3] = '{24'h0000ff, 24'h00007f, 24'h00003f};
	assign outv = {isolClosed_q, calActive_q, calBipolar_q, calBigAmp_q, calRoute_q,
		progAmpGain_q, overallGain_q};
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc[0]) msClk <= ~msClk;
		if (cyc == 40000) begin
			fails++;
			conclude();
		end
	end
	ecgfr_top dut (.ref_clk(ref_clk), .arst_n(arst_n), .csN(csN), .sclk(sclk), .sdi(sdi),
		.sdo_q(sdo_q), .sdoOe_q(sdoOe_q), .masterSampleClock(msClk),
		.sampleStrobe(sampleStrobe), .sampleData(sampleData), .sampleOut_q(sampleOut_q),
		.sampleOutValid_q(sampleOutValid_q), .sampleOutTag_q(sampleOutTag_q),
		.fastSettle_q(fastSettle_q), .isolClosed_q(isolClosed_q), .calActive_q(calActive_q),
		.calHigh_q(calHigh_q), .calBipolar_q(calBipolar_q), .calBigAmp_q(calBigAmp_q),
		.calRoute_q(calRoute_q), .progAmpGain_q(progAmpGain_q), .overallGain_q(overallGain_q));
	// A released data line shows the inverse of the last bit, so a missing enable is caught.
	ecgfr_host_model host (.clk(ref_clk), .sdo(sdoOe_q ? sdo_q : ~sdo_q), .csN(csN),
		.sclk(sclk), .sdi(sdi));
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [6:0] ad, input logic [23:0] dat);
		host.xfer({ad, 1'b0, dat}, rd);
	endtask : wr
	task automatic rdc(input string what, input logic [6:0] ad, input logic [23:0] exp);
		host.xfer({ad, 1'b1, 24'h000000}, rd);
		chk(what, exp, rd);
	endtask : rdc
	// Signs alternate so both thresholds are crossed.
	task automatic samp(input int n, input logic signed [17:0] v);
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk) sampleStrobe <= 1'b1;
			sampleData <= (i % 2) ? -v : v;
			@(posedge ref_clk) sampleStrobe <= 1'b0;
			@(posedge ref_clk);
			if (sampleOutTag_q === 1'b1) tags++;
		end
	endtask : samp
	// The first rise only synchronises; a config change may cut that period short.
	task automatic calMeas(input logic [23:0] per, input logic [23:0] hi);
		@(posedge calHigh_q);
		@(posedge calHigh_q);
		// Time is used because the cycle count updates in the same edge region as the pulse.
		t = $time;
		@(negedge calHigh_q);
		chk("cal high", hi, 24'(($time - t) / 10));
		@(posedge calHigh_q);
		chk("cal period", per, 24'(($time - t) / 10));
	endtask : calMeas
	task automatic conclude;
		$display("Compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude
	initial begin
		repeat (16) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		// Switches open in row 5 before calibration is enabled in row 7.
		for (int i = 0; i < 9; i++) begin
			{a, d, o} = rows[i];
			wr(a, d);
			repeat (3) @(posedge ref_clk);
			chk("outputs", {8'h00, o}, {8'h00, outv});
			rdc("readback", a, d);
		end
		$display("Test table done");
		wr(7'h20, 24'hffffff);
		rdc("unmapped", 7'h20, 24'h000000);
		wr(7'h06, 24'hffffff);
		rdc("status", 7'h06, 24'h000000);
		$display("Test refused done");
		calMeas(24'd512, 24'd256);
		wr(7'h12, 24'h401004);
		calMeas(24'd2048, 24'd20);
		$display("Test calibration done");
		for (int k = 0; k < 3; k++) begin
			wr(7'h15, {2'(k), 22'h000000});
			wr(7'h05, 24'h810000);
			samp(limN[k], 18'sh00801);
			repeat (3) @(posedge ref_clk);
			chk("early settle", 24'h0, {23'h0, fastSettle_q});
			samp(1, 18'sh00801);
			repeat (2) @(posedge ref_clk);
			chk("settle", 24'h1, {23'h0, fastSettle_q});
			tags = 0;
			samp(int'(setN[k]) + 8, 18'sh00000);
			chk("tagged", setN[k], 24'(tags));
			chk("settle end", 24'h0, {23'h0, fastSettle_q});
		end
		$display("Test rates done");
		samp(10, 18'sh00bb8);
		samp(15, 18'sh00800);
		rdc("watch", 7'h06, 24'h010000);
		samp(1, 18'sh00800);
		rdc("idle", 7'h06, 24'h000000);
		samp(16, 18'sh00bb8);
		chk("no settle", 24'h0, {23'h0, fastSettle_q});
		$display("Test below done");
		wr(7'h05, 24'hc10000);
		samp(40, 18'sh00bb8);
		rdc("reserved", 7'h06, 24'h000000);
		wr(7'h05, 24'h400000);
		repeat (3) @(posedge ref_clk);
		chk("manual on", 24'h1, {23'h0, fastSettle_q});
		tags = 0;
		samp(4, 18'sh00000);
		chk("manual tags", 24'h4, 24'(tags));
		wr(7'h05, 24'h000000);
		repeat (3) @(posedge ref_clk);
		chk("manual off", 24'h0, {23'h0, fastSettle_q});
		$display("Test modes done");
		wr(7'h14, 24'h800000);
		@(posedge ref_clk) arst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk("reset outputs", 24'h000014, {8'h00, outv});
		arst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rdc("reset reg", 7'h14, 24'h000000);
		$display("Test reset done");
		conclude();
	end
endmodule : ecgfr_tb
